// >>> flash_prog_regs.svh
// constants of the flash program command path: opcodes, status bits, timing
// assumes a 200 MHz core clock and a 24-bit byte address space
//
// Functional notes
// - opcode 02h programs 1 to 256 erased bytes
// - page program uses single line throughout
// - opcode is eight clocks, msb first
// - address is 24 clocks, bit 23 first
// - data bytes msb first; unsent bytes untouched
// - chip select release starts timed programming
// - busy shows in bit 0 of status
// - opcode 25h drives busy onto serial out
// - release off byte boundary aborts, clears latch
// - protected target: no program, latch cleared
// - data past page end wraps in page
// - only last 256 data bytes kept
// - incomplete address or data aborts, clears latch
// - failed byte sets program error flag
// - opcodes ADh/AFh enter sequential program mode
// - first sequential transfer carries address
// - later sequential transfers carry data only
// - sequential mode keeps write latch set
// - only last data byte kept per transfer
// - last unprotected byte ends mode, clears latch
`ifndef FLASH_PROG_REGS_SVH
`define FLASH_PROG_REGS_SVH

`define FL_OP_PAGE 8'h02
`define FL_OP_SEQ_A 8'had
`define FL_OP_SEQ_B 8'haf
`define FL_OP_WREN 8'h06
`define FL_OP_WRDI 8'h04
`define FL_OP_ASI 8'h25
`define FL_ERASED 8'hff
`define FL_PAGE_BYTES 9'h100
`define FL_ADDR_BYTES 2'h3
`define FL_SR1_BUSY_BIT 0
`define FL_SR1_WEL_BIT 1
`define FL_CLK_NS 5
`define FL_PAGE_PROG_NS 100000
`define FL_BYTE_PROG_NS 10000

`endif

// >>> flash_prog_pkg.sv
// types shared by the flash program command path
// assumes flash_prog_regs.svh supplies the numeric constants
package flash_prog_pkg;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } pins_t;

    typedef struct packed {
        logic en;
        logic [23:0] addr;
        logic [7:0] data;
    } mem_wr_t;

    typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_DATA, PH_STAT, PH_SKIP}
        phase_t;

    typedef enum logic [2:0] {CMD_NONE, CMD_PAGE, CMD_SEQ1, CMD_SEQN,
        CMD_WREN, CMD_WRDI, CMD_ASI} cmd_t;

    typedef enum logic [1:0] {PG_IDLE, PG_SCAN, PG_CHECK, PG_WAIT} pg_t;

endpackage : flash_prog_pkg

// >>> pin_sync.sv
// two-flop synchroniser for pins arriving from outside the core clock
// assumes the pins are slow against the core clock
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // pins in, synchronised levels out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            // idle bus: chip select high, so all ones
            meta_r <= '1;
            o_sync <= '1;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : pin_sync

// >>> page_buf.sv
// one page of write data held in flip-flops, with a written mask
// assumes one write per cycle and that clear and write never coincide
`timescale 1ns/1ps
module page_buf
    import flash_prog_pkg::*;
#(
    parameter int DEPTH = 256
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // write side
    input wire logic i_clr,
    input wire logic i_we,
    input wire logic [7:0] i_widx,
    input wire logic [7:0] i_wdata,
    // read side
    input wire logic [7:0] i_ridx,
    output logic [7:0] o_rdata,
    output logic o_rvalid
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] data;
        logic [DEPTH-1:0] valid;
    } buf_st_t;

    buf_st_t st_r;
    buf_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (i_clr)
            st_nxt.valid = '0;
        else if (i_we)
        begin
            // a later byte at the same index overwrites: last 256 kept
            st_nxt.data[i_widx] = i_wdata;
            st_nxt.valid[i_widx] = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_rdata = st_r.data[i_ridx];
    assign o_rvalid = st_r.valid[i_ridx];
endmodule : page_buf

// >>> flash_prog.sv
// serial command path for page program and sequential program
// assumes mode 0 spi pins, a memory array with combinational read-back
// of the last written address, and protection from i_prot_start upward
`timescale 1ns/1ps
`include "flash_prog_regs.svh"
module flash_prog
    import flash_prog_pkg::*;
#(
    parameter int PAGE_PROG_NS = `FL_PAGE_PROG_NS,
    parameter int BYTE_PROG_NS = `FL_BYTE_PROG_NS
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // spi pins
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    // protection: addresses at or above this are locked
    input wire logic [23:0] i_prot_start,
    // memory array
    output mem_wr_t o_mem_wr,
    input wire logic [7:0] i_mem_rd_data,
    // status
    output logic [7:0] o_status_reg_one,
    output logic o_program_error_flag,
    output logic o_seq_mode
);

////////////////////////////////////////////////////////////////////////////
    // round up: the array needs at least this long
    localparam int PAGE_CYC = (PAGE_PROG_NS + `FL_CLK_NS - 1) / `FL_CLK_NS;
    localparam int BYTE_CYC = (BYTE_PROG_NS + `FL_CLK_NS - 1) / `FL_CLK_NS;

    typedef struct packed {
        phase_t ph;
        cmd_t cmd;
        logic [2:0] bitcnt;
        logic [1:0] abytes;
        logic [7:0] sh;
        logic [23:0] addr;
        logic got_data;
        logic [7:0] last_byte;
        logic [7:0] widx;
        logic [8:0] nbytes;
        logic sck_q;
        logic cs_q;
        logic write_latch_flag;
        logic busy;
        logic perr;
        logic seq_mode;
        logic seq_prog;
        logic [23:0] seq_addr;
        pg_t pg;
        logic [8:0] pidx;
        logic [23:0] pbase;
        logic [31:0] timer;
        logic so;
        logic so_oe;
        mem_wr_t mem;
        logic [7:0] sr1;
    } st_t;

    st_t st_r;
    st_t st_nxt;
    pins_t pin_s;
    logic [7:0] b;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic buf_clr;
    logic buf_we;
    logic [7:0] buf_rdata;
    logic buf_rvalid;
    logic prog_cmd;

    function automatic logic is_prot(input logic [23:0] a,
                                     input logic [23:0] lim);
        is_prot = (a >= lim);
    endfunction : is_prot

////////////////////////////////////////////////////////////////////////////
    pin_sync #(.W(3)) u_sync (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_async({i_cs_n, i_sck, i_si}),
        .o_sync(pin_s)
    );

    page_buf #(.DEPTH(256)) u_buf (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_clr(buf_clr),
        .i_we(buf_we),
        .i_widx(st_r.widx),
        .i_wdata(b),
        .i_ridx(st_r.pidx[7:0]),
        .o_rdata(buf_rdata),
        .o_rvalid(buf_rvalid)
    );

    assign cs_fall = st_r.cs_q && !pin_s.cs_n;
    assign cs_rise = !st_r.cs_q && pin_s.cs_n;
    assign sck_rise = !st_r.sck_q && pin_s.sck && !pin_s.cs_n;
    assign prog_cmd = (st_r.cmd == CMD_PAGE) || (st_r.cmd == CMD_SEQ1) ||
                      (st_r.cmd == CMD_SEQN);

////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        b = {st_r.sh[6:0], pin_s.si};
        buf_clr = 1'b0;
        buf_we = 1'b0;
        st_nxt.mem.en = 1'b0;
        st_nxt.sck_q = pin_s.sck;
        st_nxt.cs_q = pin_s.cs_n;

        // program engine: one byte per two cycles, then the timed wait
        if (st_r.timer != 32'h0)
            st_nxt.timer = st_r.timer - 32'h1;
        case (st_r.pg)
            PG_IDLE: ;
            PG_SCAN:
            begin
                if (st_r.seq_prog)
                begin
                    st_nxt.mem = '{1'b1, st_r.seq_addr, st_r.last_byte};
                    st_nxt.pidx = `FL_PAGE_BYTES;
                    st_nxt.pg = PG_CHECK;
                end
                else if (st_r.pidx == `FL_PAGE_BYTES)
                    st_nxt.pg = PG_WAIT;
                else if (buf_rvalid)
                begin
                    // only sent bytes are written; the rest keep contents
                    st_nxt.mem = '{1'b1, st_r.pbase | {16'h0, st_r.pidx[7:0]},
                                   buf_rdata};
                    st_nxt.pg = PG_CHECK;
                end
                else
                    st_nxt.pidx = st_r.pidx + 9'h1;
            end
            PG_CHECK:
            begin
                if (i_mem_rd_data != st_r.mem.data)
                    st_nxt.perr = 1'b1;
                st_nxt.pidx = (st_r.pidx == `FL_PAGE_BYTES) ? st_r.pidx :
                              st_r.pidx + 9'h1;
                st_nxt.pg = (st_r.pidx == `FL_PAGE_BYTES) ? PG_WAIT : PG_SCAN;
            end
            PG_WAIT:
            begin
                if (st_r.timer == 32'h0)
                begin
                    st_nxt.busy = 1'b0;
                    st_nxt.pg = PG_IDLE;
                    if (st_r.seq_prog)
                    begin
                        st_nxt.seq_addr = st_r.seq_addr + 24'h1;
                        // no skipping over locked blocks: leave the mode
                        if (st_r.seq_addr == 24'hffffff ||
                            is_prot(st_r.seq_addr + 24'h1, i_prot_start))
                        begin
                            st_nxt.seq_mode = 1'b0;
                            st_nxt.write_latch_flag = 1'b0;
                        end
                    end
                end
            end
            default: st_nxt.pg = PG_IDLE;
        endcase

        // serial front end
        if (cs_fall)
        begin
            st_nxt.ph = PH_OPC;
            st_nxt.cmd = CMD_NONE;
            st_nxt.bitcnt = 3'h0;
            st_nxt.abytes = 2'h0;
            st_nxt.got_data = 1'b0;
            st_nxt.nbytes = 9'h0;
        end
        else if (sck_rise)
        begin
            st_nxt.sh = b;
            st_nxt.bitcnt = st_r.bitcnt + 3'h1;
            if (st_r.bitcnt == 3'h7)
            begin
                case (st_r.ph)
                    PH_OPC:
                    begin
                        st_nxt.ph = PH_SKIP;
                        // a busy array hears only the status opcode
                        if (b == `FL_OP_ASI)
                        begin
                            st_nxt.cmd = CMD_ASI;
                            st_nxt.ph = PH_STAT;
                        end
                        else if (st_r.busy)
                            st_nxt.cmd = CMD_NONE;
                        else if (b == `FL_OP_PAGE && !st_r.seq_mode)
                        begin
                            st_nxt.cmd = CMD_PAGE;
                            st_nxt.ph = PH_ADDR;
                            buf_clr = 1'b1;
                        end
                        else if (b == `FL_OP_SEQ_A || b == `FL_OP_SEQ_B)
                        begin
                            st_nxt.cmd = st_r.seq_mode ? CMD_SEQN
                                                       : CMD_SEQ1;
                            st_nxt.ph = st_r.seq_mode ? PH_DATA
                                                      : PH_ADDR;
                        end
                        else if (b == `FL_OP_WREN)
                            st_nxt.cmd = CMD_WREN;
                        else if (b == `FL_OP_WRDI)
                            st_nxt.cmd = CMD_WRDI;
                        else
                            st_nxt.cmd = CMD_NONE;
                    end
                    PH_ADDR:
                    begin
                        st_nxt.addr = {st_r.addr[15:0], b};
                        st_nxt.abytes = st_r.abytes + 2'h1;
                        if (st_r.abytes == `FL_ADDR_BYTES - 2'h1)
                        begin
                            st_nxt.ph = PH_DATA;
                            st_nxt.widx = b;
                        end
                    end
                    PH_DATA:
                    begin
                        st_nxt.got_data = 1'b1;
                        st_nxt.last_byte = b;
                        if (st_r.cmd == CMD_PAGE)
                        begin
                            buf_we = 1'b1;
                            // wraps inside the page by 8-bit overflow
                            st_nxt.widx = st_r.widx + 8'h1;
                            if (st_r.nbytes != `FL_PAGE_BYTES)
                                st_nxt.nbytes = st_r.nbytes + 9'h1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        else if (cs_rise)
        begin
            st_nxt.ph = PH_SKIP;
            case (st_r.cmd)
                CMD_WREN:
                    if (st_r.bitcnt == 3'h0)
                        st_nxt.write_latch_flag = 1'b1;
                CMD_WRDI:
                    if (st_r.bitcnt == 3'h0)
                    begin
                        st_nxt.write_latch_flag = 1'b0;
                        st_nxt.seq_mode = 1'b0;
                    end
                CMD_PAGE, CMD_SEQ1, CMD_SEQN:
                begin
                    if (st_r.bitcnt != 3'h0 || st_r.ph != PH_DATA ||
                        !st_r.got_data)
                    begin
                        st_nxt.write_latch_flag = 1'b0;
                        st_nxt.seq_mode = 1'b0;
                    end
                    else if (!st_r.write_latch_flag)
                        st_nxt.write_latch_flag = 1'b0;
                    else if (st_r.cmd != CMD_SEQN &&
                             is_prot(st_r.addr, i_prot_start))
                        st_nxt.write_latch_flag = 1'b0;
                    else
                    begin
                        st_nxt.busy = 1'b1;
                        st_nxt.perr = 1'b0;
                        st_nxt.pg = PG_SCAN;
                        st_nxt.pidx = 9'h0;
                        st_nxt.seq_prog = (st_r.cmd != CMD_PAGE);
                        st_nxt.pbase = {st_r.addr[23:8], 8'h0};
                        st_nxt.timer = (st_r.cmd != CMD_PAGE ||
                                        st_r.nbytes == 9'h1) ?
                                       32'(BYTE_CYC) : 32'(PAGE_CYC);
                        if (st_r.cmd == CMD_PAGE)
                            st_nxt.write_latch_flag = 1'b0;
                        else
                            st_nxt.seq_mode = 1'b1;
                        if (st_r.cmd == CMD_SEQ1)
                            st_nxt.seq_addr = st_r.addr;
                        else if (st_r.cmd == CMD_SEQN)
                            st_nxt.pbase = {st_r.seq_addr[23:8], 8'h0};
                    end
                end
                default: ;
            endcase
        end

        // serial out follows busy every cycle once 25h is in
        st_nxt.so_oe = (st_nxt.ph == PH_STAT) && !pin_s.cs_n;
        st_nxt.so = st_nxt.so_oe & st_r.busy;
        st_nxt.sr1 = 8'h0;
        st_nxt.sr1[`FL_SR1_BUSY_BIT] = st_nxt.busy;
        st_nxt.sr1[`FL_SR1_WEL_BIT] = st_nxt.write_latch_flag;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_r <= '0;
            st_r.cs_q <= 1'b1;
            st_r.ph <= PH_SKIP;
        end
        else
            st_r <= st_nxt;
    end

    assign o_so = st_r.so;
    assign o_so_oe = st_r.so_oe;
    assign o_mem_wr = st_r.mem;
    assign o_status_reg_one = st_r.sr1;
    assign o_program_error_flag = st_r.perr;
    assign o_seq_mode = st_r.seq_mode;

////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_end_full;
        cs_rise && prog_cmd && st_r.bitcnt == 3'h0 &&
        st_r.ph == PH_DATA && st_r.got_data;
    endsequence

    sequence s_end_ok;
        s_end_full ##0 (st_r.write_latch_flag && (st_r.cmd == CMD_SEQN ||
                        !is_prot(st_r.addr, i_prot_start)));
    endsequence

    property p_abort_partial;
        cs_rise && prog_cmd && st_r.bitcnt != 3'h0 |=>
            !st_r.write_latch_flag && !st_r.busy && st_r.pg == PG_IDLE;
    endproperty
    a_abort_partial: assert property (p_abort_partial)
        else $error("partial byte did not abort");

    property p_start_busy;
        s_end_ok |=> st_r.busy ##1 o_status_reg_one[0];
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("program did not start on release");

    property p_page_wel;
        s_end_ok ##0 st_r.cmd == CMD_PAGE |=> !st_r.write_latch_flag [*2];
    endproperty
    a_page_wel: assert property (p_page_wel)
        else $error("latch not cleared at page program");

    property p_seq_wel;
        s_end_ok ##0 st_r.cmd != CMD_PAGE |=> st_r.write_latch_flag && st_r.seq_mode;
    endproperty
    a_seq_wel: assert property (p_seq_wel)
        else $error("latch lost in sequential mode");

    property p_protected;
        s_end_full ##0 st_r.cmd != CMD_SEQN &&
            is_prot(st_r.addr, i_prot_start) |=> !st_r.write_latch_flag && !st_r.busy;
    endproperty
    a_protected: assert property (p_protected)
        else $error("protected target programmed");

    property p_so_busy;
        st_r.ph == PH_STAT && !pin_s.cs_n && !cs_rise |=>
            o_so_oe && o_so == $past(st_r.busy);
    endproperty
    a_so_busy: assert property (p_so_busy)
        else $error("serial out does not track busy");

    property p_in_page;
        o_mem_wr.en && !st_r.seq_prog |->
            o_mem_wr.addr[23:8] == st_r.pbase[23:8];
    endproperty
    a_in_page: assert property (p_in_page)
        else $error("page write left its page");

    property p_seq_incr;
        st_r.pg == PG_WAIT && st_r.timer == 32'h0 && st_r.seq_prog |=>
            st_r.seq_addr == $past(st_r.seq_addr) + 24'h1 && !st_r.busy;
    endproperty
    a_seq_incr: assert property (p_seq_incr)
        else $error("sequential counter not advanced");

    property p_verify;
        st_r.pg == PG_CHECK && i_mem_rd_data != st_r.mem.data |=>
            o_program_error_flag;
    endproperty
    a_verify: assert property (p_verify)
        else $error("program failure not flagged");

endmodule : flash_prog

// >>> spi_host.sv
// spi host model: drives chip select, serial clock and data in, mode 0
// assumes the core clock paces it; serial clock period is 32 core cycles
`timescale 1ns/1ps
module spi_host (
    // core clock pacing the model
    input wire logic i_core_clk,
    // spi pins toward the device
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    initial
    begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic frame_start;
        @(posedge i_core_clk);
        o_cs_n <= 1'b0;
        repeat (16) @(posedge i_core_clk);
    endtask : frame_start
    // every phase on the one data line, msb first
    task automatic shift(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            o_si <= b[7-i];
            repeat (16) @(posedge i_core_clk);
            o_sck <= 1'b1;
            repeat (16) @(posedge i_core_clk);
            o_sck <= 1'b0;
        end
    endtask : shift
    // data line flips on release so a stale bit cannot pass for a real one
    task automatic frame_end;
        repeat (16) @(posedge i_core_clk);
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        repeat (8) @(posedge i_core_clk);
    endtask : frame_end
endmodule : spi_host

// >>> testbench.sv
// self-checking bench for the flash program command path
// assumes spi_host as the host and a small array model here
`timescale 1ns/1ps
module testbench;
    import flash_prog_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [23:0] prot_start = 24'hffffff;
    logic cs_n, sck, si, so, so_oe, err, seq;
    logic [7:0] sr1, rd;
    mem_wr_t wr;
    logic [7:0] mem [0:8191];
    int failures = 0;
    int n_tests = 0;
    always #2.5 i_core_clk = ~i_core_clk;
    spi_host host (.i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_sck(sck),
        .o_si(si));
    // short program times keep the run small
    flash_prog #(.PAGE_PROG_NS(2000), .BYTE_PROG_NS(50)) dut (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_cs_n(cs_n),
        .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe),
        .i_prot_start(prot_start), .o_mem_wr(wr), .i_mem_rd_data(rd),
        .o_status_reg_one(sr1), .o_program_error_flag(err),
        .o_seq_mode(seq));
    // flash cells only clear bits, so a write is an and; read-back shows
    // the written result in the strobe cycle, where the verify looks
    assign rd = mem[wr.addr[12:0]] & ((wr.en === 1'b1) ? wr.data : 8'hff);
    always @(posedge i_core_clk)
        if (wr.en === 1'b1)
            mem[wr.addr[12:0]] <= mem[wr.addr[12:0]] & wr.data;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic wait_idle;
        int k;
        k = 0;
        while (sr1[0] !== 1'b0 && k < 3000)
        begin
            @(posedge i_core_clk);
            k++;
        end
        if (k == 3000)
        begin
            failures++;
            end_of_test();
        end
    endtask : wait_idle
    task automatic xfer(input logic [7:0] b [$], input int extra);
        host.frame_start();
        foreach (b[i])
            host.shift(b[i], 8);
        if (extra > 0)
            host.shift(8'h00, extra);
        host.frame_end();
        wait_idle();
    endtask : xfer
    task automatic wren;
        xfer('{8'h06}, 0);
    endtask : wren
    ////////////////////////////////////////////////////////////////////////
    // wrap in page, then watch busy on the serial out until it falls
    task automatic t_page_wrap;
        int k;
        wren();
        host.frame_start();
        host.shift(8'h02, 8);
        host.shift(8'h00, 8);
        host.shift(8'h00, 8);
        host.shift(8'hfe, 8);
        host.shift(8'h11, 8);
        host.shift(8'h22, 8);
        host.shift(8'h33, 8);
        host.frame_end();
        check(sr1, 8'h01);
        host.frame_start();
        host.shift(8'h25, 8);
        @(posedge i_core_clk);
        check({6'h0, so_oe, so}, 8'h03);
        k = 0;
        while (so !== 1'b0 && k < 1000)
        begin
            @(posedge i_core_clk);
            k++;
        end
        if (k == 1000)
        begin
            failures++;
            end_of_test();
        end
        check({7'h0, sr1[0]}, 8'h00);
        host.frame_end();
        check(mem[13'h0fe], 8'h11);
        check(mem[13'h0ff], 8'h22);
        check(mem[13'h000], 8'h33);
        check(mem[13'h001], 8'hff);
        check({7'h0, err}, 8'h00);
    endtask : t_page_wrap
    // refused: no latch, off-boundary end, short address, protected target
    task automatic t_refused;
        xfer('{8'h02, 8'h00, 8'h01, 8'h00, 8'h44}, 0);
        check(mem[13'h100], 8'hff);
        wren();
        xfer('{8'h02, 8'h00, 8'h01, 8'h00, 8'h44}, 3);
        check(mem[13'h100], 8'hff);
        check(sr1, 8'h00);
        wren();
        xfer('{8'h02, 8'h00, 8'h01}, 0);
        check(sr1, 8'h00);
        @(posedge i_core_clk);
        prot_start <= 24'h001000;
        wren();
        xfer('{8'h02, 8'h00, 8'h10, 8'h00, 8'h55}, 0);
        check(mem[13'h1000], 8'hff);
        check(sr1, 8'h00);
    endtask : t_refused
    // sequential run up to the protected boundary, then a fresh run ended by write disable
    task automatic t_seq;
        wren();
        xfer('{8'had, 8'h00, 8'h0f, 8'hfe, 8'h66, 8'h77}, 0);
        check(mem[13'h0ffe], 8'h77);
        check({seq, sr1[6:0]}, 8'h82);
        xfer('{8'haf, 8'h88}, 0);
        check(mem[13'h0fff], 8'h88);
        check({seq, sr1[6:0]}, 8'h00);
        wren();
        xfer('{8'haf, 8'h00, 8'h08, 8'h00, 8'h99}, 0);
        check(mem[13'h0800], 8'h99);
        xfer('{8'h04}, 0);
        check({seq, sr1[6:0]}, 8'h00);
    endtask : t_seq
    // a cell that is not erased fails verify
    task automatic t_err;
        mem[13'h300] = 8'h00;
        wren();
        xfer('{8'h02, 8'h00, 8'h03, 8'h00, 8'ha5}, 0);
        check({7'h0, err}, 8'h01);
    endtask : t_err
    // 257 bytes: the first one is overwritten by the last
    task automatic t_big;
        wren();
        host.frame_start();
        host.shift(8'h02, 8);
        host.shift(8'h00, 8);
        host.shift(8'h02, 8);
        host.shift(8'h00, 8);
        for (int i = 0; i < 256; i++)
            host.shift(8'(i) ^ 8'h5a, 8);
        host.shift(8'hc3, 8);
        host.frame_end();
        wait_idle();
        check(mem[13'h200], 8'hc3);
        check(mem[13'h201], 8'h5b);
        check(mem[13'h2ff], 8'ha5);
    endtask : t_big
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'hff;
        repeat (6) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        check({seq, sr1[6:0]}, 8'h00);
        t_page_wrap();
        t_err();
        t_big();
        t_refused();
        t_seq();
        end_of_test();
    end
endmodule : testbench
